// file: hdl/stepper_pkg.sv
package stepper_pkg;

  // Clock and time base
  localparam int CLK_FREQ_HZ = 250_000_000;
  localparam int US_PER_S = 1_000_000;
  localparam int CYC_PER_US = CLK_FREQ_HZ / US_PER_S;
  localparam int WAKE_TIME_US = 40;

  // Step clock half period, in microseconds
  localparam int HP_W = 14;
  localparam int HP_DEFAULT_US = 1000;
  localparam int HP_MAX_US = 16383;
  localparam int DEFAULT_RATE_HZ = 500;
  localparam int HP_RATE_NUM = US_PER_S / 2;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HALF_PERIOD = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_STEPS = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // Control register fields
  localparam int CTRL_W = 6;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PS_BIT = 1;
  localparam int CTRL_DIR_BIT = 2;
  localparam int CTRL_MODE_LSB = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WAKE_BIT = 1;
  localparam int STAT_FALLBACK_BIT = 2;
  localparam int STAT_REFUSED_BIT = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Stepping modes as software selects them
  typedef enum logic [2:0] {
    MODE_FULL = 3'b000,
    MODE_HALF = 3'b001,
    MODE_HALF_A = 3'b010,
    MODE_HALF_B = 3'b011,
    MODE_QUARTER = 3'b100,
    MODE_EIGHTH = 3'b101,
    MODE_SIXTEENTH = 3'b110
  } step_mode_t;

  // Codes on the two mode select lines
  typedef enum logic [1:0] {
    PIN_FULL = 2'b00,
    PIN_HALF = 2'b01,
    PIN_QUARTER = 2'b10,
    PIN_SIXTEENTH = 2'b11
  } pin_mode_t;

  // Electrical position in sixteenth steps, four full steps per cycle
  localparam int POS_W = 6;
  localparam logic [POS_W-1:0] POS_HOME = 6'h00;
  localparam logic [POS_W-1:0] INC_FULL = 6'h10;
  localparam logic [POS_W-1:0] INC_HALF = 6'h08;
  localparam logic [POS_W-1:0] INC_QUARTER = 6'h04;
  localparam logic [POS_W-1:0] INC_SIXTEENTH = 6'h01;

  // Host step generator states
  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_WAKE = 2'b01,
    GEN_RUN = 2'b10
  } gen_state_t;

endpackage

// file: hdl/stepper_link_if.sv
`timescale 1ns/10ps
interface stepper_link_if;
  logic step_clk;
  logic rotation_dir_sel;
  logic step_mode_bit0;
  logic step_mode_bit1;
  logic out_enable;
  logic power_save_n;

  // Host drives every line, driver only listens
  modport host (
    output step_clk,
    output rotation_dir_sel,
    output step_mode_bit0,
    output step_mode_bit1,
    output out_enable,
    output power_save_n
  );
  modport driver (
    input step_clk,
    input rotation_dir_sel,
    input step_mode_bit0,
    input step_mode_bit1,
    input out_enable,
    input power_save_n
  );
endinterface

// file: hdl/us_tick.sv
`timescale 1ns/10ps
module us_tick #(
  parameter int CYC_PER_US = stepper_pkg::CYC_PER_US
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  output logic tick
);
  localparam int CW = (CYC_PER_US > 1) ? $clog2(CYC_PER_US) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYC_PER_US - 1);

  if (CYC_PER_US < 1) begin : g_bad_rate
    $error("us_tick needs at least one cycle per microsecond");
  end

  logic [CW-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  // One pulse per microsecond, restarted by clear
  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q + CW'(1);
    if (clear) begin
      cnt_d = '0;
    end else if (cnt_q == LAST) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule // us_tick

// file: hdl/stepper_driver.sv
`timescale 1ns/10ps
module stepper_driver (
  input wire logic aclk,
  input wire logic aresetn,
  stepper_link_if.driver link,
  output logic drive_en,
  output logic phase_a,
  output logic phase_b,
  output logic [stepper_pkg::POS_W-1:0] step_pos
);

  // Position increment for each code on the mode lines
  function automatic logic [stepper_pkg::POS_W-1:0] mode_inc(input logic [1:0] code);
    case (code)
      stepper_pkg::PIN_FULL: mode_inc = stepper_pkg::INC_FULL;
      stepper_pkg::PIN_HALF: mode_inc = stepper_pkg::INC_HALF;
      stepper_pkg::PIN_QUARTER: mode_inc = stepper_pkg::INC_QUARTER;
      default: mode_inc = stepper_pkg::INC_SIXTEENTH;
    endcase
  endfunction

  logic clk_prev_q, clk_prev_d;
  logic [stepper_pkg::POS_W-1:0] pos_q, pos_d;
  logic drive_q, drive_d;
  logic pa_q, pa_d;
  logic pb_q, pb_d;
  logic active, rise;

  // Step on each rising edge while both enables are high
  always_comb begin
    active = link.out_enable & link.power_save_n;
    rise = link.step_clk & ~clk_prev_q;
    clk_prev_d = link.step_clk;
    pos_d = pos_q;
    if (!link.power_save_n) begin
      pos_d = stepper_pkg::POS_HOME; // RULE4
    end else if (active && rise) begin // RULE2
      if (link.rotation_dir_sel) begin // RULE10
        pos_d = pos_q + mode_inc({link.step_mode_bit1, link.step_mode_bit0}); // RULE6
      end else begin
        pos_d = pos_q - mode_inc({link.step_mode_bit1, link.step_mode_bit0}); // RULE11
      end
    end
    drive_d = active; // RULE2
    // Phase polarity follows the kept position, so re-enable restores it
    pa_d = ~(pos_d[5] ^ pos_d[4]); // RULE3
    pb_d = ~pos_d[5];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev_q <= 1'b0;
      pos_q <= stepper_pkg::POS_HOME;
      drive_q <= 1'b0;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_prev_d;
      pos_q <= pos_d;
      drive_q <= drive_d;
      pa_q <= pa_d;
      pb_q <= pb_d;
    end
  end

  assign drive_en = drive_q;
  assign phase_a = pa_q;
  assign phase_b = pb_q;
  assign step_pos = pos_q;
endmodule // stepper_driver

// file: hdl/stepper_host.sv
// Contract
// [RULE1] Host holds enable and power-save high to drive
// [RULE2] Disabled driver floats outputs, ignores step clock
// [RULE3] Re-enable restores previous phase state
// [RULE4] Power-save floats outputs, homes position on release
// [RULE5] Wait 40us after power-save release before stepping; the host waits only if the releasing control write also sets enable
// [RULE6] One step per complete step clock cycle
// [RULE7] Half period defaults 1000us, set as us or Hz
// [RULE8] Half period capped at 16383us
// [RULE9] N steps means N cycles, count never negative
// [RULE10] Direction line picks clockwise or counterclockwise
// [RULE11] Seven stepping modes, full default, subset supported
// [RULE12] Mode presented on two select lines
// [RULE13] Toggle clock at half period, stop after count
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module stepper_host #(
  parameter int CYC_PER_US = stepper_pkg::CYC_PER_US,
  parameter int WAKE_US = stepper_pkg::WAKE_TIME_US
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  stepper_link_if.host link
);
  localparam int HP_W = stepper_pkg::HP_W;

  if (WAKE_US < 1 || WAKE_US > stepper_pkg::HP_MAX_US || CYC_PER_US < 1) begin : g_bad_param
    $error("stepper_host wake time or clock rate out of range");
  end

  // Byte-lane merge of a write into the old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? wr[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // Keeps the half period inside 1..16383 us
  function automatic logic [HP_W-1:0] clamp_hp(input logic [31:0] v);
    if (v == 32'h0000_0000) begin
      clamp_hp = HP_W'(1);
    end else if (v > 32'(stepper_pkg::HP_MAX_US)) begin
      clamp_hp = HP_W'(stepper_pkg::HP_MAX_US); // RULE8
    end else begin
      clamp_hp = v[HP_W-1:0];
    end
  endfunction

  // Maps a software mode onto the two select lines, unsupported modes fall back to full
  function automatic logic [2:0] mode_code(input logic [2:0] m);
    case (m)
      stepper_pkg::MODE_FULL: mode_code = {1'b0, stepper_pkg::PIN_FULL};
      stepper_pkg::MODE_HALF: mode_code = {1'b0, stepper_pkg::PIN_HALF};
      stepper_pkg::MODE_QUARTER: mode_code = {1'b0, stepper_pkg::PIN_QUARTER};
      stepper_pkg::MODE_SIXTEENTH: mode_code = {1'b0, stepper_pkg::PIN_SIXTEENTH};
      default: mode_code = {1'b1, stepper_pkg::PIN_FULL};
    endcase
  endfunction

  // Bus slave state
  logic awready_q, awready_d, wready_q, wready_d;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  // Controller state
  logic [stepper_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [HP_W-1:0] hp_q, hp_d;
  logic [31:0] rate_q, rate_d;
  logic [31:0] steps_q, steps_d;
  logic [HP_W-1:0] us_cnt_q, us_cnt_d;
  logic clk_q, clk_d;
  logic [1:0] pin_mode_q, pin_mode_d;
  logic fallback_q, fallback_d, refused_q, refused_d;
  stepper_pkg::gen_state_t state_q, state_d;

  logic tick, tick_clear;
  logic aw_take, w_take, do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_word, rd_word;
  logic [2:0] code;

  us_tick #(.CYC_PER_US(CYC_PER_US)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(tick_clear),
    .tick(tick)
  );

  // Register read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      stepper_pkg::OFS_CTRL: rd_word = 32'(ctrl_q);
      stepper_pkg::OFS_HALF_PERIOD: rd_word = 32'(hp_q);
      stepper_pkg::OFS_RATE: rd_word = rate_q;
      stepper_pkg::OFS_STEPS: rd_word = steps_q;
      stepper_pkg::OFS_STATUS: begin
        rd_word[stepper_pkg::STAT_BUSY_BIT] = (state_q != stepper_pkg::GEN_IDLE);
        rd_word[stepper_pkg::STAT_WAKE_BIT] = (state_q == stepper_pkg::GEN_WAKE);
        rd_word[stepper_pkg::STAT_FALLBACK_BIT] = fallback_q;
        rd_word[stepper_pkg::STAT_REFUSED_BIT] = refused_q;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Bus handshakes, register writes and the step generator
  always_comb begin
    aw_take = s_axi_awvalid & awready_q;
    w_take = s_axi_wvalid & wready_q;
    aw_got_d = aw_got_q | aw_take;
    w_got_d = w_got_q | w_take;
    awaddr_d = aw_take ? s_axi_awaddr : awaddr_q;
    wdata_d = w_take ? s_axi_wdata : wdata_q;
    wstrb_d = w_take ? s_axi_wstrb : wstrb_q;
    wr_addr = awaddr_d;
    bvalid_d = bvalid_q & ~s_axi_bready;
    bresp_d = bresp_q;
    do_write = aw_got_d & w_got_d & ~bvalid_q;
    rvalid_d = rvalid_q & ~s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    ctrl_d = ctrl_q;
    hp_d = hp_q;
    rate_d = rate_q;
    steps_d = steps_q;
    us_cnt_d = us_cnt_q;
    clk_d = clk_q;
    pin_mode_d = pin_mode_q;
    fallback_d = fallback_q;
    refused_d = refused_q;
    state_d = state_q;
    tick_clear = 1'b0;
    wr_word = 32'h0000_0000;
    code = 3'h0;

    // Step clock: toggle at each half period, count on the falling edge
    if (state_q == stepper_pkg::GEN_WAKE && tick) begin
      if (32'(us_cnt_q) + 32'd1 >= 32'(WAKE_US)) begin // RULE5
        us_cnt_d = '0;
        tick_clear = 1'b1;
        state_d = (steps_q != 32'h0000_0000) ? stepper_pkg::GEN_RUN : stepper_pkg::GEN_IDLE;
      end else begin
        us_cnt_d = us_cnt_q + HP_W'(1);
      end
    end else if (state_q == stepper_pkg::GEN_RUN && tick) begin
      if (us_cnt_q + HP_W'(1) >= hp_q) begin // RULE13
        us_cnt_d = '0;
        clk_d = ~clk_q;
        if (clk_q) begin
          steps_d = steps_q - 32'd1; // RULE9
          if (steps_q == 32'd1) begin
            state_d = stepper_pkg::GEN_IDLE; // RULE13
          end
        end
      end else begin
        us_cnt_d = us_cnt_q + HP_W'(1);
      end
    end

    if (do_write) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = stepper_pkg::RESP_OKAY;
      case (wr_addr)
        stepper_pkg::OFS_CTRL: begin
          wr_word = merge(32'(ctrl_q), wdata_d, wstrb_d);
          ctrl_d = wr_word[stepper_pkg::CTRL_W-1:0];
          code = mode_code(wr_word[stepper_pkg::CTRL_MODE_LSB +: 3]);
          pin_mode_d = code[1:0]; // RULE12
          fallback_d = code[2]; // RULE11
          if (!wr_word[stepper_pkg::CTRL_PS_BIT] || !wr_word[stepper_pkg::CTRL_EN_BIT]) begin
            state_d = stepper_pkg::GEN_IDLE; // RULE1
            steps_d = 32'h0000_0000;
            clk_d = 1'b0;
          end else if (!ctrl_q[stepper_pkg::CTRL_PS_BIT]) begin
            state_d = stepper_pkg::GEN_WAKE; // RULE5
            steps_d = 32'h0000_0000;
            us_cnt_d = '0;
            tick_clear = 1'b1;
            clk_d = 1'b0;
          end
        end
        stepper_pkg::OFS_HALF_PERIOD: begin
          hp_d = clamp_hp(merge(32'(hp_q), wdata_d, wstrb_d)); // RULE7
        end
        stepper_pkg::OFS_RATE: begin
          wr_word = merge(rate_q, wdata_d, wstrb_d);
          if (wr_word != 32'h0000_0000) begin
            rate_d = wr_word;
            hp_d = clamp_hp(32'(stepper_pkg::HP_RATE_NUM) / wr_word); // RULE7
          end
        end
        stepper_pkg::OFS_STEPS: begin
          wr_word = merge(32'h0000_0000, wdata_d, wstrb_d);
          if (wr_word[31] || steps_q != 32'h0000_0000 || state_q == stepper_pkg::GEN_RUN ||
              !ctrl_q[stepper_pkg::CTRL_PS_BIT] || !ctrl_q[stepper_pkg::CTRL_EN_BIT]) begin
            refused_d = 1'b1; // RULE9
          end else if (wr_word != 32'h0000_0000) begin
            steps_d = wr_word;
            if (state_q == stepper_pkg::GEN_IDLE) begin
              state_d = stepper_pkg::GEN_RUN;
              us_cnt_d = '0;
              tick_clear = 1'b1;
            end
          end
        end
        stepper_pkg::OFS_STATUS: begin
          wr_word = merge(32'h0000_0000, wdata_d, wstrb_d);
          // Writing one to the refused bit clears the flag
          if (wr_word[stepper_pkg::STAT_REFUSED_BIT]) begin
            refused_d = 1'b0;
          end
        end
        default: bresp_d = stepper_pkg::RESP_SLVERR;
      endcase
    end
    awready_d = ~aw_got_d & ~bvalid_d;
    wready_d = ~w_got_d & ~bvalid_d;

    // Read answers one cycle after the address is taken
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rdata_d = rd_word;
      rresp_d = (s_axi_araddr > stepper_pkg::OFS_STATUS || s_axi_araddr[1:0] != 2'h0) ?
                stepper_pkg::RESP_SLVERR : stepper_pkg::RESP_OKAY;
    end
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      ctrl_q <= stepper_pkg::CTRL_RESET;
      hp_q <= HP_W'(stepper_pkg::HP_DEFAULT_US); // RULE7
      rate_q <= 32'(stepper_pkg::DEFAULT_RATE_HZ);
      steps_q <= 32'h0000_0000;
      us_cnt_q <= '0;
      clk_q <= 1'b0;
      pin_mode_q <= stepper_pkg::PIN_FULL; // RULE11
      fallback_q <= 1'b0;
      refused_q <= 1'b0;
      state_q <= stepper_pkg::GEN_IDLE;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
      hp_q <= hp_d;
      rate_q <= rate_d;
      steps_q <= steps_d;
      us_cnt_q <= us_cnt_d;
      clk_q <= clk_d;
      pin_mode_q <= pin_mode_d;
      fallback_q <= fallback_d;
      refused_q <= refused_d;
      state_q <= state_d;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign link.step_clk = clk_q;
  assign link.rotation_dir_sel = ctrl_q[stepper_pkg::CTRL_DIR_BIT];
  assign link.step_mode_bit0 = pin_mode_q[0]; // RULE12
  assign link.step_mode_bit1 = pin_mode_q[1];
  assign link.out_enable = ctrl_q[stepper_pkg::CTRL_EN_BIT]; // RULE1
  assign link.power_save_n = ctrl_q[stepper_pkg::CTRL_PS_BIT];
endmodule // stepper_host

// file: tb/stepper_link_props.sv
`timescale 1ns/10ps
module stepper_link_props #(
  parameter int HP_CYC = 4,
  parameter int WAKE_CYC = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step_clk,
  input wire logic rotation_dir_sel,
  input wire logic step_mode_bit0,
  input wire logic step_mode_bit1,
  input wire logic out_enable,
  input wire logic power_save_n,
  input wire logic drive_en,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic [stepper_pkg::POS_W-1:0] step_pos
);
  logic [5:0] inc;
  logic [5:0] nxt_pos;
  logic clk_q;
  logic [15:0] lvl_q, lvl_d;
  logic [15:0] wake_q, wake_d;

  // Position expected after one step in the present mode and direction
  assign inc = step_mode_bit1 ? (step_mode_bit0 ? 6'h01 : 6'h04) : (step_mode_bit0 ? 6'h08 : 6'h10);
  assign nxt_pos = rotation_dir_sel ? step_pos + inc : step_pos - inc;

  // Cycles at the present clock level and since power-save release
  always_comb begin
    lvl_d = (step_clk != clk_q) ? 16'h0001 : lvl_q + {15'h0000, lvl_q != 16'hFFFF};
    wake_d = power_save_n ? wake_q + {15'h0000, wake_q != 16'hFFFF} : 16'h0000;
  end

  // Counter registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_q <= 1'b0;
      lvl_q <= 16'h0000;
      wake_q <= 16'h0000;
    end else begin
      clk_q <= step_clk;
      lvl_q <= lvl_d;
      wake_q <= wake_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Rising step clock seen while the driver is on
  sequence step_seen;
    $rose(step_clk) && out_enable && power_save_n;
  endsequence

  // Leaving power save
  sequence ps_release;
    $rose(power_save_n);
  endsequence

  chk_drive_on: assert property (out_enable && power_save_n |=> drive_en)
    else $error("outputs not driven while enabled");
  chk_drive_off: assert property (!(out_enable && power_save_n) |=> !drive_en)
    else $error("outputs driven while off");
  chk_step_once: assert property (step_seen |=> step_pos == $past(nxt_pos))
    else $error("step size or direction wrong");
  chk_pos_frozen: assert property (power_save_n && !($rose(step_clk) && out_enable) |=> $stable(step_pos))
    else $error("position moved without a step");
  chk_phase_held: assert property (power_save_n && !out_enable |=> $stable({phase_a, phase_b}))
    else $error("phases changed while disabled");
  chk_ps_home: assert property (!power_save_n |=> step_pos == stepper_pkg::POS_HOME)
    else $error("position not home in power save");
  chk_home_release: assert property (ps_release |-> step_pos == stepper_pkg::POS_HOME)
    else $error("position not home at release");
  chk_wake_gap: assert property ($rose(step_clk) |-> wake_q >= WAKE_CYC)
    else $error("step clock too soon after wake");
  chk_high_half: assert property ($fell(step_clk) && out_enable && power_save_n |-> lvl_q == HP_CYC)
    else $error("high half period wrong");
  chk_low_half: assert property ($rose(step_clk) |-> lvl_q >= HP_CYC)
    else $error("low half period too short");
  chk_clk_stop: assert property ($fell(out_enable) |-> ##[0:1] !step_clk)
    else $error("step clock left high after disable");
endmodule // stepper_link_props

// file: tb/test_stepper_step_dir_control.sv
`timescale 1ns/10ps
module test_stepper_step_dir_control;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic drive_en, phase_a, phase_b;
  logic [5:0] step_pos;
  logic [5:0] pos_seen = 6'h00, pos_m = 6'h00;
  logic clk_seen = 1'b0;
  logic [33:0] exp_q[$];
  logic [5:0] pos_q[$];
  int rises = 0;
  int fail_count = 0;
  int n_compared = 0;

  stepper_link_if link();
  stepper_host #(.CYC_PER_US(2), .WAKE_US(2)) i_stepper_host (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link(link));
  stepper_driver i_stepper_driver (.aclk(aclk), .aresetn(aresetn), .link(link), .drive_en(drive_en),
    .phase_a(phase_a), .phase_b(phase_b), .step_pos(step_pos));
  stepper_link_props #(.HP_CYC(4), .WAKE_CYC(4)) i_stepper_link_props (.aclk(aclk), .aresetn(aresetn),
    .step_clk(link.step_clk), .rotation_dir_sel(link.rotation_dir_sel), .step_mode_bit0(link.step_mode_bit0),
    .step_mode_bit1(link.step_mode_bit1), .out_enable(link.out_enable), .power_save_n(link.power_save_n),
    .drive_en(drive_en), .phase_a(phase_a), .phase_b(phase_b), .step_pos(step_pos));

  // Clock at 250 MHz
  always #2 aclk = ~aclk;

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Bus write: address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(negedge aclk); while (!awready);
        @(posedge aclk);
        awvalid <= 1'b0;
      end
      begin
        do @(negedge aclk); while (!wready);
        @(posedge aclk);
        wvalid <= 1'b0;
      end
    join
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  // Bus read
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic ctrl(input logic en, input logic ps, input logic dir, input logic [2:0] m);
    axi_wr(stepper_pkg::OFS_CTRL, {26'h0, m, dir, ps, en}, stepper_pkg::RESP_OKAY);
    @(negedge aclk);
  endtask

  function automatic logic [1:0] pin_of(input logic [2:0] m);
    return m == 3'h1 ? 2'b01 : m == 3'h4 ? 2'b10 : m == 3'h6 ? 2'b11 : 2'b00;
  endfunction

  function automatic logic [5:0] inc_of(input logic [2:0] m);
    return m == 3'h1 ? 6'h08 : m == 3'h4 ? 6'h04 : m == 3'h6 ? 6'h01 : 6'h10;
  endfunction

  // Wait until enough rising step edges, optionally until the clock is low again
  task automatic wait_rise(input int target, input logic low);
    for (int k = 0; k < 4000 && (rises < target || (low && link.step_clk)); k++) begin
      @(negedge aclk);
    end
    check({33'h0, rises >= target && !(low && link.step_clk)}, 34'h1);
  endtask

  // Note expected positions, start the move and wait for its end
  task automatic run_steps(input int n, input logic [2:0] m, input logic dir);
    int target;
    target = rises + n;
    for (int i = 0; i < n; i++) begin
      pos_m = dir ? pos_m + inc_of(m) : pos_m - inc_of(m);
      pos_q.push_back(pos_m);
    end
    axi_wr(stepper_pkg::OFS_STEPS, 32'(n), stepper_pkg::RESP_OKAY);
    wait_rise(target, 1'b1);
  endtask

  // Monitor: bus answers and position changes against the oldest note
  always @(negedge aclk) begin
    if (bvalid && bready) check({bresp, 32'h0}, exp_q.pop_front());
    if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
    if (aresetn && step_pos !== pos_seen) check({28'h0, step_pos}, {28'h0, pos_q.pop_front()});
    if (aresetn) pos_seen = step_pos;
    if (link.step_clk && !clk_seen) rises++;
    clk_seen = link.step_clk;
  end

  // Main sequence
  initial begin
    logic dir;
    int n;
    void'($urandom(67718));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and an unmapped address
    axi_rd(stepper_pkg::OFS_CTRL, 32'h0, stepper_pkg::RESP_OKAY);
    axi_rd(stepper_pkg::OFS_HALF_PERIOD, 32'(stepper_pkg::HP_DEFAULT_US), stepper_pkg::RESP_OKAY);
    axi_rd(stepper_pkg::OFS_RATE, 32'(stepper_pkg::DEFAULT_RATE_HZ), stepper_pkg::RESP_OKAY);
    axi_rd(stepper_pkg::OFS_STATUS, 32'h0, stepper_pkg::RESP_OKAY);
    axi_rd(8'h14, 32'h0, stepper_pkg::RESP_SLVERR);
    wstrb <= 4'($urandom);
    axi_wr(8'h14, $urandom, stepper_pkg::RESP_SLVERR);
    wstrb <= 4'hF;
    // Rate in hertz, half period cap, then a short half period
    axi_wr(stepper_pkg::OFS_RATE, 32'h0003_D090, stepper_pkg::RESP_OKAY);
    axi_rd(stepper_pkg::OFS_HALF_PERIOD, 32'(stepper_pkg::HP_RATE_NUM / 250000), stepper_pkg::RESP_OKAY);
    axi_wr(stepper_pkg::OFS_HALF_PERIOD, 32'h0000_4E20, stepper_pkg::RESP_OKAY);
    axi_rd(stepper_pkg::OFS_HALF_PERIOD, 32'(stepper_pkg::HP_MAX_US), stepper_pkg::RESP_OKAY);
    axi_wr(stepper_pkg::OFS_HALF_PERIOD, 32'h0000_0002, stepper_pkg::RESP_OKAY);
    // Every stepping mode with random direction and count
    for (int m = 0; m < 7; m++) begin
      dir = 1'($urandom);
      n = $urandom_range(3, 1);
      ctrl(1'b1, 1'b1, dir, 3'(m));
      check({32'h0, link.step_mode_bit1, link.step_mode_bit0}, {32'h0, pin_of(3'(m))});
      check({33'h0, link.rotation_dir_sel}, {33'h0, dir});
      check({33'h0, drive_en}, 34'h1);
      run_steps(n, 3'(m), dir);
      axi_rd(stepper_pkg::OFS_STATUS, (m == 2 || m == 3 || m == 5) ? 32'h4 : 32'h0, stepper_pkg::RESP_OKAY);
    end
    ctrl(1'b1, 1'b1, 1'b1, 3'h0);
    // Negative count refused, flag cleared by writing one
    axi_wr(stepper_pkg::OFS_STEPS, 32'h8000_0003, stepper_pkg::RESP_OKAY);
    axi_rd(stepper_pkg::OFS_STATUS, 32'h8, stepper_pkg::RESP_OKAY);
    axi_wr(stepper_pkg::OFS_STATUS, 32'h8, stepper_pkg::RESP_OKAY);
    // Disable in mid-move: move aborted, new count refused, position kept
    pos_m = pos_m + 6'h10;
    pos_q.push_back(pos_m);
    n = rises + 1;
    axi_wr(stepper_pkg::OFS_STEPS, 32'h3, stepper_pkg::RESP_OKAY);
    wait_rise(n, 1'b0);
    ctrl(1'b0, 1'b1, 1'b1, 3'h0);
    check({33'h0, drive_en}, 34'h0);
    axi_rd(stepper_pkg::OFS_STEPS, 32'h0, stepper_pkg::RESP_OKAY);
    axi_wr(stepper_pkg::OFS_STEPS, 32'h2, stepper_pkg::RESP_OKAY);
    axi_rd(stepper_pkg::OFS_STATUS, 32'h8, stepper_pkg::RESP_OKAY);
    axi_wr(stepper_pkg::OFS_STATUS, 32'h8, stepper_pkg::RESP_OKAY);
    ctrl(1'b1, 1'b1, 1'b0, 3'h0);
    check({26'h0, phase_a, phase_b, step_pos}, {26'h0, ~(pos_m[5] ^ pos_m[4]), ~pos_m[5], pos_m});
    run_steps(2, 3'h0, 1'b0);
    // Power save homes the position, first step waits for wake-up
    if (pos_m !== 6'h00) pos_q.push_back(6'h00);
    pos_m = 6'h00;
    ctrl(1'b1, 1'b0, 1'b1, 3'h0);
    check({33'h0, drive_en}, 34'h0);
    ctrl(1'b1, 1'b1, 1'b1, 3'h0);
    run_steps(2, 3'h0, 1'b1);
    check(34'(pos_q.size()), 34'h0);
    wrap_up;
  end

  // Watchdog
  initial begin
    #200000;
    fail_count++;
    wrap_up;
  end
endmodule // test_stepper_step_dir_control
